/* File: logic/acc_regs.svh */
// Register map, field positions, codes and timing counts of the converter configuration block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
//
// Summary of operation
// - Overrun mode 0 keeps old result, 1 overwrites.
// - Trigger edge: software, rising, falling, both edges.
// - Trigger source 000 timer output, 001 channel four.
// - Alignment bit selects right or left justification.
// - Resolution field selects 12, 10, 8, 6 bits.
// - Scan direction: up 0..11 or down 11..0.
// - Clock codes 0000..0110 divide peripheral clock 1..64.
// - Clock codes 1000..1100 divide internal oscillator.
// - Sampling field sets one duration for all channels.
// - Continuous mode repeats sequences until bit cleared.
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// Register byte offsets
`define ACC_OFS_STATUS 8'h00
`define ACC_OFS_CTRL 8'h08
`define ACC_OFS_CFG 8'h0C
`define ACC_OFS_CLKCFG 8'h10
`define ACC_OFS_SMPCFG 8'h14
`define ACC_OFS_RESULT 8'h40

// Writable bits and reset values
`define ACC_CFG_MASK 32'h0001_3DFC
`define ACC_CLK_MASK 32'hF000_0000
`define ACC_STIME_MASK 32'h0000_0007
`define ACC_CFG_RESET 32'h0000_0000
`define ACC_CLK_RESET 32'h0000_0000
`define ACC_STIME_RESET 32'h0000_0000

// Configuration register fields
`define ACC_F_DISC 16
`define ACC_F_REPEAT 13
`define ACC_F_OVR 12
`define ACC_F_EDGE 11:10
`define ACC_F_SRC 8:6
`define ACC_F_ALIGN 5
`define ACC_F_RES 4:3
`define ACC_F_SCAN 2
`define ACC_F_CLK 31:28
`define ACC_F_STIME 2:0

// Control register bits
`define ACC_C_EN 0
`define ACC_C_CAL 1
`define ACC_C_START 2
`define ACC_C_STOP 4

// Status register bits
`define ACC_S_EOC 2
`define ACC_S_EOS 3
`define ACC_S_OVR 4

// Trigger edge and source codes
`define ACC_EDGE_SW 2'h0
`define ACC_EDGE_RISE 2'h1
`define ACC_EDGE_FALL 2'h2
`define ACC_EDGE_BOTH 2'h3
`define ACC_SRC_ZERO 3'h0
`define ACC_SRC_ONE 3'h1

// Resolution codes and the shifts that fit a 12-bit core sample
`define ACC_RES_12 2'h0
`define ACC_RES_10 2'h1
`define ACC_RES_8 2'h2
`define ACC_RES_6 2'h3
`define ACC_RSH_12 4'h0
`define ACC_RSH_10 4'h2
`define ACC_RSH_8 4'h4
`define ACC_RSH_6 4'h6
`define ACC_LSH_12 4'h4
`define ACC_LSH_10 4'h6
`define ACC_LSH_8 4'h8
`define ACC_LSH_6 4'hA

// Conversion length in converter clock cycles (bits plus half, rounded up)
`define ACC_CONV_12 9'h00D
`define ACC_CONV_10 9'h00B
`define ACC_CONV_8 9'h009
`define ACC_CONV_6 9'h007

// Sampling codes and lengths in converter cycles (half cycles rounded up)
`define ACC_ST_3P5 3'h0
`define ACC_ST_5P5 3'h1
`define ACC_ST_7P5 3'h2
`define ACC_ST_13P5 3'h3
`define ACC_ST_28P5 3'h4
`define ACC_ST_41P5 3'h5
`define ACC_ST_239P5 3'h7
`define ACC_SMPN_3P5 9'h004
`define ACC_SMPN_5P5 9'h006
`define ACC_SMPN_7P5 9'h008
`define ACC_SMPN_13P5 9'h00E
`define ACC_SMPN_28P5 9'h01D
`define ACC_SMPN_41P5 9'h02A
`define ACC_SMPN_239P5 9'h0F0

// Converter clock codes and divider shifts
`define ACC_CK_PCLK_LAST 4'h6
`define ACC_CK_OSC_FIRST 4'h8
`define ACC_CK_OSC_LAST 4'hC
`define ACC_CK_OSC_DIV64 4'hC
`define ACC_SH_DIV64 3'h6

// Channel sequence ends
`define ACC_CHAN_LOW 4'h0
`define ACC_CHAN_HIGH 4'hB

`endif

/* File: logic/acc_pkg.sv */
// Types shared by the converter configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package acc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_SAMPLE,
		ST_CONVERT
	} acc_state_t;
endpackage

/* File: logic/acc_edge_sync.sv */
// Three-stage synchroniser with edge pulses for one asynchronous input.
// Assumes the input level holds for several clock periods.
module acc_edge_sync (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Asynchronous level in
	input wire logic sig_i,
	// Edge pulses out
	output logic rise_o,
	output logic fall_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;
	wire agree = (s2_reg == s3_reg);

	// Shift chain; the level only moves once stages two and three agree
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			lvl_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= sig_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (agree)
				lvl_reg <= s3_reg;
		end
	end

	// Edges of the filtered level
	assign rise_o = agree & s3_reg & ~lvl_reg;
	assign fall_o = agree & ~s3_reg & lvl_reg;
endmodule

/* File: logic/acc_clk_div.sv */
// Power-of-two divider that turns input steps into converter clock ticks.
// Assumes step_i is a one-cycle enable on the system clock.
module acc_clk_div (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic run_i,
	input wire logic step_i,
	input wire logic [2:0] shift_i,
	// Tick out
	output logic tick_o
);
	logic [5:0] cnt_reg;
	logic [5:0] cnt_next;
	wire [5:0] mask = 6'((7'h01 << shift_i) - 7'h01);
	wire wrap = ((cnt_reg & mask) == mask);

	// Count steps and emit a tick every 2^shift of them
	assign cnt_next = (!run_i || (step_i && wrap)) ? 6'h00 : (step_i ? 6'(cnt_reg + 6'h01) : cnt_reg);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_reg <= 6'h00;
			tick_o <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			tick_o <= run_i & step_i & wrap;
		end
	end
endmodule

/* File: logic/acc_top.sv */
// Converter configuration and sequencing block with its Wishbone register file.
// Assumes an analog core that samples while core_sample_o is high and presents a
// 12-bit result on core_data_i by the end of core_convert_o, on the same clock.
`include "acc_regs.svh"

module acc_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Asynchronous trigger and reference inputs
	input wire logic trigger_input_zero_i,
	input wire logic trigger_input_one_i,
	input wire logic fast_osc_ref_i,
	// Analog core
	input wire logic [11:0] core_data_i,
	output logic core_sample_o,
	output logic core_convert_o,
	output logic [3:0] core_channel_o,
	output logic [1:0] core_resolution_o,
	output logic core_calibrate_o,
	output logic core_osc_select_o
);
	acc_pkg::acc_state_t state_reg;
	acc_pkg::acc_state_t state_next;
	logic [31:0] cfg_reg;
	logic [31:0] cfg_next;
	logic [31:0] clk_reg;
	logic [31:0] clk_next;
	logic [31:0] stime_reg;
	logic [31:0] stime_next;
	logic en_reg;
	logic run_reg;
	logic eoc_reg;
	logic eos_reg;
	logic ovr_reg;
	logic [15:0] result_reg;
	logic [8:0] cnt_reg;
	logic [8:0] cnt_next;
	logic [3:0] chan_reg;
	logic [3:0] chan_next;
	logic store;
	logic seq_end;
	logic run_clear;
	logic [8:0] stime_cycles;
	logic [8:0] conv_cycles;
	logic [3:0] rshift;
	logic [3:0] lshift;
	logic [2:0] div_shift;
	logic ack_reg;
	logic [31:0] rdat_reg;

	// Bus decode
	wire wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire wr = wb_req & wb_we_i;
	wire rd = wb_req & ~wb_we_i;
	wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire hit_stat = (wb_adr_i == `ACC_OFS_STATUS);
	wire hit_ctrl = (wb_adr_i == `ACC_OFS_CTRL);
	wire hit_cfg = (wb_adr_i == `ACC_OFS_CFG);
	wire hit_clk = (wb_adr_i == `ACC_OFS_CLKCFG);
	wire hit_stime = (wb_adr_i == `ACC_OFS_SMPCFG);
	wire hit_res = (wb_adr_i == `ACC_OFS_RESULT);
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_stat = wr & hit_stat;

	// Byte-masked configuration writes; software keeps them to quiet moments
	assign cfg_next = (wr & hit_cfg) ? ((cfg_reg & ~(wmask & `ACC_CFG_MASK))
		| (wb_dat_i & wmask & `ACC_CFG_MASK)) : cfg_reg;
	assign clk_next = (wr & hit_clk) ? ((clk_reg & ~(wmask & `ACC_CLK_MASK))
		| (wb_dat_i & wmask & `ACC_CLK_MASK)) : clk_reg;
	assign stime_next = (wr & hit_stime) ? ((stime_reg & ~(wmask & `ACC_STIME_MASK))
		| (wb_dat_i & wmask & `ACC_STIME_MASK)) : stime_reg;

	// Configuration fields
	wire discontinuous_enable = cfg_reg[`ACC_F_DISC];
	wire continuous_mode = cfg_reg[`ACC_F_REPEAT];
	wire overrun_mode = cfg_reg[`ACC_F_OVR];
	wire [1:0] trigger_edge_select = cfg_reg[`ACC_F_EDGE];
	wire [2:0] trigger_source_select = cfg_reg[`ACC_F_SRC];
	wire align_left = cfg_reg[`ACC_F_ALIGN];
	wire [1:0] resolution_select = cfg_reg[`ACC_F_RES];
	wire scan_direction = cfg_reg[`ACC_F_SCAN];
	wire [3:0] converter_clock_select = clk_reg[`ACC_F_CLK];
	wire [2:0] sampling_time_select = stime_reg[`ACC_F_STIME];

	// Control strobes
	wire en_wr = wr_ctrl & wb_sel_i[0];
	wire start_req = en_wr & wb_dat_i[`ACC_C_START] & en_reg;
	wire stop_req = en_wr & wb_dat_i[`ACC_C_STOP];
	wire cal_req = en_wr & wb_dat_i[`ACC_C_CAL] & ~en_reg;
	wire abort = stop_req | ~en_reg;

	// Trigger inputs pass the synchroniser before edge selection
	wire rise0;
	wire fall0;
	wire rise1;
	wire fall1;
	wire osc_rise;
	wire osc_fall;
	acc_edge_sync u_sync_src0 (.clk_i(clk_i), .rst_i(rst_i), .sig_i(trigger_input_zero_i),
		.rise_o(rise0), .fall_o(fall0));
	acc_edge_sync u_sync_src1 (.clk_i(clk_i), .rst_i(rst_i), .sig_i(trigger_input_one_i),
		.rise_o(rise1), .fall_o(fall1));
	acc_edge_sync u_sync_osc (.clk_i(clk_i), .rst_i(rst_i), .sig_i(fast_osc_ref_i),
		.rise_o(osc_rise), .fall_o(osc_fall));

	// Source and edge selection; reserved sources never fire
	wire src_zero = (trigger_source_select == `ACC_SRC_ZERO);
	wire src_one = (trigger_source_select == `ACC_SRC_ONE);
	wire t_rise = (src_zero & rise0) | (src_one & rise1);
	wire t_fall = (src_zero & fall0) | (src_one & fall1);
	wire trig_hit = ((trigger_edge_select == `ACC_EDGE_RISE) & t_rise)
		| ((trigger_edge_select == `ACC_EDGE_FALL) & t_fall)
		| ((trigger_edge_select == `ACC_EDGE_BOTH) & (t_rise | t_fall));
	wire sw_mode = (trigger_edge_select == `ACC_EDGE_SW);
	wire go = sw_mode ? start_req : trig_hit;

	// Converter clock source and divider; reserved codes give no ticks
	wire osc_src = (converter_clock_select >= `ACC_CK_OSC_FIRST);
	wire ck_valid = (converter_clock_select <= `ACC_CK_PCLK_LAST)
		| (osc_src & (converter_clock_select <= `ACC_CK_OSC_LAST));
	assign div_shift = (converter_clock_select == `ACC_CK_OSC_DIV64) ? `ACC_SH_DIV64
		: converter_clock_select[2:0];
	wire step = osc_src ? (osc_rise | osc_fall) : 1'b1;
	wire busy = (state_reg == acc_pkg::ST_SAMPLE) | (state_reg == acc_pkg::ST_CONVERT);
	wire tick;
	acc_clk_div u_div (.clk_i(clk_i), .rst_i(rst_i), .run_i(busy & ck_valid), .step_i(step),
		.shift_i(div_shift), .tick_o(tick));

	// Sampling length; reserved code takes the longest setting
	always_comb
	begin
		unique case (sampling_time_select)
			`ACC_ST_3P5: stime_cycles = `ACC_SMPN_3P5;
			`ACC_ST_5P5: stime_cycles = `ACC_SMPN_5P5;
			`ACC_ST_7P5: stime_cycles = `ACC_SMPN_7P5;
			`ACC_ST_13P5: stime_cycles = `ACC_SMPN_13P5;
			`ACC_ST_28P5: stime_cycles = `ACC_SMPN_28P5;
			`ACC_ST_41P5: stime_cycles = `ACC_SMPN_41P5;
			default: stime_cycles = `ACC_SMPN_239P5;
		endcase
	end

	// Conversion length and result shifts per resolution
	always_comb
	begin
		unique case (resolution_select)
			`ACC_RES_12:
			begin
				conv_cycles = `ACC_CONV_12;
				rshift = `ACC_RSH_12;
				lshift = `ACC_LSH_12;
			end
			`ACC_RES_10:
			begin
				conv_cycles = `ACC_CONV_10;
				rshift = `ACC_RSH_10;
				lshift = `ACC_LSH_10;
			end
			`ACC_RES_8:
			begin
				conv_cycles = `ACC_CONV_8;
				rshift = `ACC_RSH_8;
				lshift = `ACC_LSH_8;
			end
			`ACC_RES_6:
			begin
				conv_cycles = `ACC_CONV_6;
				rshift = `ACC_RSH_6;
				lshift = `ACC_LSH_6;
			end
		endcase
	end

	// Result formatting
	wire [15:0] right_word = {4'h0, 12'(core_data_i >> rshift)};
	wire [15:0] left_word = 16'(right_word << lshift);
	wire [15:0] new_word = align_left ? left_word : right_word;

	// Channel walk ends
	wire [3:0] chan_first = scan_direction ? `ACC_CHAN_HIGH : `ACC_CHAN_LOW;
	wire [3:0] chan_last = scan_direction ? `ACC_CHAN_LOW : `ACC_CHAN_HIGH;
	wire [3:0] chan_step = scan_direction ? 4'(chan_reg - 4'h1) : 4'(chan_reg + 4'h1);

	// Sequencer
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		chan_next = chan_reg;
		store = 1'b0;
		seq_end = 1'b0;
		run_clear = 1'b0;
		unique case (state_reg)
			acc_pkg::ST_IDLE:
			begin
				if (start_req)
				begin
					chan_next = chan_first;
					cnt_next = 9'h000;
					state_next = sw_mode ? acc_pkg::ST_SAMPLE : acc_pkg::ST_ARMED;
				end
			end
			acc_pkg::ST_ARMED:
			begin
				if (go)
				begin
					cnt_next = 9'h000;
					state_next = acc_pkg::ST_SAMPLE;
				end
			end
			acc_pkg::ST_SAMPLE:
			begin
				if (tick)
				begin
					cnt_next = (cnt_reg == 9'(stime_cycles - 9'h001)) ? 9'h000 : 9'(cnt_reg + 9'h001);
					if (cnt_reg == 9'(stime_cycles - 9'h001))
						state_next = acc_pkg::ST_CONVERT;
				end
			end
			acc_pkg::ST_CONVERT:
			begin
				if (tick)
				begin
					cnt_next = 9'(cnt_reg + 9'h001);
					if (cnt_reg == 9'(conv_cycles - 9'h001))
					begin
						store = 1'b1;
						cnt_next = 9'h000;
						if (chan_reg == chan_last)
						begin
							seq_end = 1'b1;
							chan_next = chan_first;
							if (continuous_mode)
								state_next = acc_pkg::ST_SAMPLE;
							else
							begin
								run_clear = 1'b1;
								state_next = acc_pkg::ST_IDLE;
							end
						end
						else
						begin
							chan_next = chan_step;
							state_next = discontinuous_enable ? acc_pkg::ST_ARMED : acc_pkg::ST_SAMPLE;
						end
					end
				end
			end
		endcase
		if (abort)
		begin
			state_next = acc_pkg::ST_IDLE;
			run_clear = 1'b1;
		end
	end

	// Result register update and overrun
	wire res_read = rd & hit_res;
	wire overrun = store & eoc_reg;
	wire take = store & (~eoc_reg | overrun_mode);

	// Status flags: hardware set wins over a clear
	wire eoc_next = store | (eoc_reg & ~res_read & ~(wr_stat & wb_sel_i[0] & wb_dat_i[`ACC_S_EOC]));
	wire eos_next = seq_end | (eos_reg & ~(wr_stat & wb_sel_i[0] & wb_dat_i[`ACC_S_EOS]));
	wire ovr_next = overrun | (ovr_reg & ~(wr_stat & wb_sel_i[0] & wb_dat_i[`ACC_S_OVR]));
	wire run_next = start_req | (run_reg & ~run_clear);
	wire en_next = en_wr ? wb_dat_i[`ACC_C_EN] : en_reg;

	// Read data
	wire [31:0] stat_word = 32'(eoc_reg) << `ACC_S_EOC | 32'(eos_reg) << `ACC_S_EOS
		| 32'(ovr_reg) << `ACC_S_OVR;
	wire [31:0] ctrl_word = 32'(en_reg) << `ACC_C_EN | 32'(run_reg) << `ACC_C_START;
	wire [31:0] rdat = hit_stat ? stat_word : hit_ctrl ? ctrl_word : hit_cfg ? cfg_reg
		: hit_clk ? clk_reg : hit_stime ? stime_reg : hit_res ? {16'h0000, result_reg} : 32'h0000_0000;

	// Bus answer one cycle after the request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg <= wb_req;
			rdat_reg <= rd ? rdat : 32'h0000_0000;
		end
	end

	// Configuration and control registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg_reg <= `ACC_CFG_RESET;
			clk_reg <= `ACC_CLK_RESET;
			stime_reg <= `ACC_STIME_RESET;
			en_reg <= 1'b0;
			run_reg <= 1'b0;
		end
		else
		begin
			cfg_reg <= cfg_next;
			clk_reg <= clk_next;
			stime_reg <= stime_next;
			en_reg <= en_next;
			run_reg <= run_next;
		end
	end

	// Sequencer state, flags and result
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= acc_pkg::ST_IDLE;
			cnt_reg <= 9'h000;
			chan_reg <= `ACC_CHAN_LOW;
			eoc_reg <= 1'b0;
			eos_reg <= 1'b0;
			ovr_reg <= 1'b0;
			result_reg <= 16'h0000;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			chan_reg <= chan_next;
			eoc_reg <= eoc_next;
			eos_reg <= eos_next;
			ovr_reg <= ovr_next;
			if (take)
				result_reg <= new_word;
		end
	end

	// Core-facing outputs, registered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			core_sample_o <= 1'b0;
			core_convert_o <= 1'b0;
			core_channel_o <= `ACC_CHAN_LOW;
			core_resolution_o <= `ACC_RES_12;
			core_calibrate_o <= 1'b0;
			core_osc_select_o <= 1'b0;
		end
		else
		begin
			core_sample_o <= (state_next == acc_pkg::ST_SAMPLE);
			core_convert_o <= (state_next == acc_pkg::ST_CONVERT);
			core_channel_o <= chan_next;
			core_resolution_o <= resolution_select;
			core_calibrate_o <= cal_req;
			core_osc_select_o <= osc_src;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
endmodule

/* File: verification/acc_top_asserts.sv */
// Port checker of the converter configuration block.
// Assumes a bind into acc_top, one clock and a synchronous reset.
`include "acc_regs.svh"
module acc_top_asserts (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Core side
	input wire logic core_sample_o,
	input wire logic core_convert_o,
	input wire logic [3:0] core_channel_o,
	input wire logic [1:0] core_resolution_o,
	input wire logic core_calibrate_o,
	input wire logic core_osc_select_o
);
	logic [1:0] res_w;
	logic osc_w;
	// Request and field-write decode
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr_cfg = req && wb_we_i && wb_sel_i[0] && wb_adr_i == `ACC_OFS_CFG;
	wire wr_clk = req && wb_we_i && wb_sel_i[3] && wb_adr_i == `ACC_OFS_CLKCFG;
	// Last written width and clock source
	always_ff @(posedge clk_i)
	begin
		if (wr_cfg)
			res_w <= wb_dat_i[`ACC_F_RES];
		if (wr_clk)
			osc_w <= wb_dat_i[31];
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (req |=> wb_ack_o)
		else $error("request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_res_follow: assert property (wr_cfg |-> ##[1:2] core_resolution_o == res_w)
		else $error("width not passed to core");
	a_osc_follow: assert property (wr_clk |-> ##[1:2] core_osc_select_o == osc_w)
		else $error("clock source not passed to core");
	a_phase_apart: assert property (!(core_sample_o && core_convert_o))
		else $error("sample and convert overlap");
	a_chan_bound: assert property (core_channel_o <= `ACC_CHAN_HIGH)
		else $error("channel out of range");
	a_cal_pulse: assert property (core_calibrate_o |=> !core_calibrate_o)
		else $error("calibrate pulse too long");
	a_cal_idle: assert property (core_calibrate_o |-> !core_sample_o && !core_convert_o)
		else $error("calibrate while converting");
endmodule

bind acc_top acc_top_asserts u_acc_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.core_sample_o(core_sample_o), .core_convert_o(core_convert_o),
	.core_channel_o(core_channel_o), .core_resolution_o(core_resolution_o),
	.core_calibrate_o(core_calibrate_o), .core_osc_select_o(core_osc_select_o));

/* File: verification/acc_core_model.sv */
// Behavioural analog core and fast oscillator beside the block.
// Assumes the block's clock and its active-high synchronous reset.
module acc_core_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Core control
	input wire logic convert_i,
	input wire logic [3:0] channel_i,
	// Sample and reference
	output logic [11:0] data_o,
	output logic osc_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] div_reg;
	logic [11:0] noise_reg;
	// Sample names its channel; outside conversion the bus churns
	assign data_o = convert_i ? {channel_i, 8'h5A} : noise_reg;
	// Oscillator edge every four cycles and a shifting idle pattern
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_reg <= 2'h0;
			osc_o <= 1'b0;
			noise_reg <= 12'hA53;
		end
		else
		begin
			div_reg <= div_reg + 2'h1;
			osc_o <= osc_o ^ (div_reg == 2'h3);
			noise_reg <= {noise_reg[10:0], ~noise_reg[11] ^ noise_reg[5]};
		end
	end
endmodule

/* File: verification/tb_acc_top.sv */
// Self-checking bench of the converter configuration block.
// Assumes the core model and the bound checker compile before it.
`include "acc_regs.svh"
`define CHECK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_acc_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, rd, c;
	logic [1:0] trg = 2'h0;
	logic [11:0] core_data;
	logic wb_ack_o, osc, samp, cnv, cal, osel;
	logic [3:0] chan;
	logic [1:0] res;
	int error_cnt = 0;
	int comparisons = 0;
	int cks [6] = '{0, 1, 6, 8, 9, 12};
	int smn [8] = '{4, 6, 8, 14, 29, 42, 240, 240};
	logic [7:0] ofs [4] = '{`ACC_OFS_CLKCFG, `ACC_OFS_SMPCFG, `ACC_OFS_CFG, 8'h20};
	logic [31:0] msk [4] = '{`ACC_CLK_MASK, `ACC_STIME_MASK, `ACC_CFG_MASK, 32'h0};
	// 25 MHz clock
	always #20 clk_i = ~clk_i;
	// Block and its analog neighbour
	acc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trigger_input_zero_i(trg[0]),
		.trigger_input_one_i(trg[1]), .fast_osc_ref_i(osc), .core_data_i(core_data),
		.core_sample_o(samp), .core_convert_o(cnv), .core_channel_o(chan),
		.core_resolution_o(res), .core_calibrate_o(cal), .core_osc_select_o(osel));
	acc_core_model model (.clk_i(clk_i), .rst_i(rst_i), .convert_i(cnv),
		.channel_i(chan), .data_o(core_data), .osc_o(osc));
	// One classic cycle, released at the edge that samples ack
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		@(posedge clk_i);
		// Only the watchdog ends a wait for the answer
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdr(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask
	// Poll a register bit until it takes a value
	task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
		int n;
		n = 0;
		rdr(a);
		while (rd[b] !== v && n < 400)
		begin
			rdr(a);
			n++;
		end
		`CHECK("awaited bit", v, rd[b])
	endtask
	// Abort, program while idle, then enable and start
	task automatic setup(input logic [31:0] cf, input logic [3:0] ck, input logic [2:0] sm);
		wr(`ACC_OFS_CTRL, 32'h0);
		wr(`ACC_OFS_STATUS, 32'h1C);
		wr(`ACC_OFS_CLKCFG, {ck, 28'h0});
		wr(`ACC_OFS_SMPCFG, {29'h0, sm});
		wr(`ACC_OFS_CFG, cf);
		wr(`ACC_OFS_CTRL, 32'h1);
		wr(`ACC_OFS_CTRL, 32'h5);
	endtask
	// Aligned result of one channel at width code k
	function automatic logic [31:0] expv(input logic [3:0] ch, input int k, input logic al);
		logic [15:0] s;
		s = {4'h0, ch, 8'h5A} >> (2 * k);
		if (al)
			s = s << (4 + 2 * k);
		return {16'h0, s};
	endfunction
	// Report whether sampling began within a short span
	task automatic look(input logic v);
		logic seen;
		seen = 1'b0;
		repeat (30)
		begin
			@(posedge clk_i);
			seen = seen | (samp === 1'b1);
		end
		`CHECK("trigger start", v, seen)
	endtask
	// Time sample and convert phases against the tick period
	task automatic measure(input logic [3:0] ck, input logic [2:0] sm, input int n);
		int d, ns, nc, w;
		d = ck < 8 ? 1 << ck : (ck == 12 ? 256 : 4 << (ck - 8));
		ns = 0;
		nc = 0;
		w = 0;
		setup(32'h0, ck, sm);
		while (samp !== 1'b1 && w < 4000)
		begin
			@(posedge clk_i);
			w++;
		end
		while (samp === 1'b1)
		begin
			@(posedge clk_i);
			ns++;
		end
		while (cnv === 1'b1)
		begin
			@(posedge clk_i);
			nc++;
		end
		`CHECK("sample length", 1'b1, ns + d >= n * d && ns <= n * d + d)
		`CHECK("convert length", 1'b1, nc + d >= 13 * d && nc <= 14 * d)
	endtask
	task automatic conclude;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 4; i++)
		begin
			rdr(ofs[i]);
			`CHECK("reset value", 32'h0, rd)
			wr(ofs[i], 32'hFFFE_FFFF);
			rdr(ofs[i]);
			`CHECK("writable bits", msk[i] & 32'hFFFE_FFFF, rd)
		end
		wr(`ACC_OFS_CTRL, 32'h2);
		rdr(`ACC_OFS_CTRL);
		`CHECK("control", 32'h0, rd)
		for (int k = 0; k < 4; k++)
		begin
			c = 32'h0;
			c[`ACC_F_RES] = k[1:0];
			c[`ACC_F_ALIGN] = k[0];
			c[`ACC_F_SCAN] = k[1];
			setup(c, 4'h0, 3'h0);
			for (int i = 0; i < 12; i++)
			begin
				wait_bit(`ACC_OFS_STATUS, `ACC_S_EOC, 1'b1);
				rdr(`ACC_OFS_RESULT);
				`CHECK("result", expv(k[1] ? 4'(11 - i) : 4'(i), k, k[0]), rd)
			end
			rdr(`ACC_OFS_CTRL);
			`CHECK("start after sequence", 1'b0, rd[`ACC_C_START])
			rdr(`ACC_OFS_STATUS);
			`CHECK("end of sequence", 1'b1, rd[`ACC_S_EOS])
		end
		for (int m = 0; m < 2; m++)
		begin
			c = 32'h0;
			c[`ACC_F_OVR] = m[0];
			setup(c, 4'h0, 3'h0);
			wait_bit(`ACC_OFS_CTRL, `ACC_C_START, 1'b0);
			rdr(`ACC_OFS_STATUS);
			`CHECK("overrun flag", 1'b1, rd[`ACC_S_OVR])
			rdr(`ACC_OFS_RESULT);
			`CHECK("kept result", expv(m ? 4'hB : 4'h0, 0, 1'b0), rd)
		end
		// Discontinuous: one channel per start, newest result kept
		c = 32'h0;
		c[`ACC_F_DISC] = 1'b1;
		c[`ACC_F_OVR] = 1'b1;
		setup(c, 4'h0, 3'h0);
		for (int i = 0; i < 2; i++)
		begin
			repeat (60) @(posedge clk_i);
			rdr(`ACC_OFS_RESULT);
			`CHECK("one channel per start", expv(4'(i), 0, 1'b0), rd)
			wr(`ACC_OFS_CTRL, 32'h5);
		end
		c = 32'h0;
		c[`ACC_F_REPEAT] = 1'b1;
		setup(c, 4'h0, 3'h0);
		repeat (600) @(posedge clk_i);
		rdr(`ACC_OFS_CTRL);
		`CHECK("start in continuous", 1'b1, rd[`ACC_C_START])
		wr(`ACC_OFS_CFG, 32'h0);
		wait_bit(`ACC_OFS_CTRL, `ACC_C_START, 1'b0);
		// Rising, falling and both-edge choices on both sources, the other source toggled first
		for (int e = 1; e < 4; e++)
			for (int s = 0; s < 2; s++)
			begin
				c = 32'h0;
				c[`ACC_F_EDGE] = e[1:0];
				c[`ACC_F_SRC] = s[2:0];
				setup(c, 4'h0, 3'h0);
				trg[1 - s] <= 1'b1;
				repeat (8) @(posedge clk_i);
				trg[1 - s] <= 1'b0;
				look(1'b0);
				trg[s] <= 1'b1;
				look(e != 2);
				trg[s] <= 1'b0;
				if (e == 2)
					look(1'b1);
				repeat (8) @(posedge clk_i);
			end
		for (int i = 0; i < 6; i++)
			measure(4'(cks[i]), 3'h0, 4);
		for (int j = 1; j < 8; j++)
			if (j != 6)
				measure(4'h1, 3'(j), smn[j]);
		conclude;
	end
	// Watchdog well past the expected run length
	initial
	begin
		#(40 * 60000);
		error_cnt++;
		conclude;
	end
endmodule
